// File: design/pir_pkg.sv
package pir_pkg;

  // ----------------------------------------------------------------
  // I/O port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PIR_PORT_INDEX  = 16'h0022;
  localparam logic [15:0] PIR_PORT_DATA   = 16'h0023;
  localparam logic [15:0] PIR_PORT_MASTER = 16'h04d0;
  localparam logic [15:0] PIR_PORT_SLAVE  = 16'h04d1;

  // ----------------------------------------------------------------
  // Configuration indices and unlock values
  // ----------------------------------------------------------------
  localparam logic [7:0] PIR_IDX_ROUTE_A  = 8'h42;
  localparam logic [7:0] PIR_IDX_ROUTE_B  = 8'h43;
  localparam logic [7:0] PIR_IDX_CONVERT  = 8'h44;
  localparam logic [7:0] PIR_UNLOCK_IDX   = 8'h03;
  localparam logic [7:0] PIR_UNLOCK_KEY   = 8'hc5;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] PIR_RST_ROUTE    = 8'h00;
  localparam logic [7:0] PIR_RST_CONVERT  = 8'h00;
  localparam logic [7:0] PIR_RST_MODE     = 8'h00;
  localparam int         PIR_FIELD_W      = 4;
  localparam int         PIR_LINES        = 4;
  localparam int         PIR_IRQS         = 16;
  localparam logic [3:0] PIR_CONVERT_MASK = 4'hf;

  // Mode bit meanings for the channel ports
  localparam logic PIR_MODE_EDGE  = 1'b0;
  localparam logic PIR_MODE_LEVEL = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIR_LOCKED   = 2'b00,
    PIR_IDX_SEEN = 2'b01,
    PIR_OPEN     = 2'b10
  } pir_lock_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pir_io_s;

  // Routing code to a one-hot IRQ vector; zero and reserved codes give none
  function automatic logic [15:0] pir_decode(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    unique case (code)
      4'b0010: v[3]  = 1'b1;
      4'b0100: v[4]  = 1'b1;
      4'b0110: v[7]  = 1'b1;
      4'b0001: v[9]  = 1'b1;
      4'b0011: v[10] = 1'b1;
      4'b0101: v[5]  = 1'b1;
      4'b0111: v[6]  = 1'b1;
      4'b1001: v[11] = 1'b1;
      4'b1011: v[12] = 1'b1;
      4'b1101: v[14] = 1'b1;
      4'b1111: v[15] = 1'b1;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : pir_decode

endpackage : pir_pkg

// File: design/pir_router.sv
`timescale 1ns/1ps
// Overview of operation
// - Indices 42h and 43h each hold two 4-bit routing fields in bits 3..0 and 7..4.
// - Code zero disconnects a line, other legal codes select IRQ3,4,7,9,10,5,6,11,12,14,15.
// - A set convert bit turns a level request into an edge, a clear one passes the level.
// - Pci_line_trigger_convert bits 0..3 belong to the first through fourth PCI line.
// - Ports 04D0h and 04D1h are read/write 8-bit channel mode registers.
// - A mode bit of 0 means edge triggered and 1 means level triggered.
// - Both channel mode ports read zero after reset.
// - Master bits 0..7 map to IRQ0..7 and slave bits 0..7 to IRQ8..15.
// - Writing 03h to port 22h then C5h to port 23h opens the indexed registers.
module pir_router
  import pir_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Host I/O cycles
  input  wire pir_io_s     io_req,
  output logic      [7:0]  io_rdata,
  output logic             io_rvalid,
  // PCI request lines, active high, from pins
  input  wire logic [3:0]  pci_request_line,
  // Requests toward the interrupt controllers
  output logic      [15:0] isa_irq_req,
  output logic      [15:0] isa_irq_level_mode
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  route_a_q;
  logic [7:0]  route_b_q;
  logic [7:0]  convert_q;
  logic [7:0]  master_mode_q;
  logic [7:0]  slave_mode_q;
  logic [7:0]  index_q;
  pir_lock_e   lock_q;
  pir_lock_e   lock_d;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic [15:0] irq_q;
  logic [15:0] mode_q;
  logic [15:0] comb_prev_q;
  logic [15:0] edge_cnt_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_index  = io_req.addr == PIR_PORT_INDEX;
  wire hit_data   = io_req.addr == PIR_PORT_DATA;
  wire hit_master = io_req.addr == PIR_PORT_MASTER;
  wire hit_slave  = io_req.addr == PIR_PORT_SLAVE;
  wire open_w     = lock_q == PIR_OPEN;
  wire wr_index   = io_req.wr && hit_index;
  wire wr_data    = io_req.wr && hit_data;
  wire cfg_wr     = wr_data && open_w;
  wire wr_route_a = cfg_wr && index_q == PIR_IDX_ROUTE_A;
  wire wr_route_b = cfg_wr && index_q == PIR_IDX_ROUTE_B;
  wire wr_convert = cfg_wr && index_q == PIR_IDX_CONVERT;
  wire wr_master  = io_req.wr && hit_master;
  wire wr_slave   = io_req.wr && hit_slave;

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  // Only the index-then-key pair opens; a data write of any other value after the
  // index relocks so a stray cycle cannot leave the window open to a wrong key.
  always_comb begin
    lock_d = lock_q;
    if (wr_index) begin
      if (io_req.wdata == PIR_UNLOCK_IDX && !open_w) begin
        lock_d = PIR_IDX_SEEN;
      end
    end else if (wr_data && lock_q == PIR_IDX_SEEN) begin
      lock_d = (io_req.wdata == PIR_UNLOCK_KEY) ? PIR_OPEN : PIR_LOCKED;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lock_q  <= PIR_LOCKED;
      index_q <= 8'h00;
    end else begin
      lock_q <= lock_d;
      if (wr_index) begin
        index_q <= io_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and channel mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      route_a_q     <= PIR_RST_ROUTE;
      route_b_q     <= PIR_RST_ROUTE;
      convert_q     <= PIR_RST_CONVERT;
      master_mode_q <= PIR_RST_MODE;
      slave_mode_q  <= PIR_RST_MODE;
    end else begin
      if (wr_route_a) begin
        route_a_q <= io_req.wdata;
      end
      if (wr_route_b) begin
        route_b_q <= io_req.wdata;
      end
      if (wr_convert) begin
        convert_q <= {4'h0, io_req.wdata[3:0] & PIR_CONVERT_MASK};
      end
      if (wr_master) begin
        master_mode_q <= io_req.wdata;
      end
      if (wr_slave) begin
        slave_mode_q <= io_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] cfg_rd = !open_w                   ? 8'h00     :
                      index_q == PIR_IDX_ROUTE_A ? route_a_q :
                      index_q == PIR_IDX_ROUTE_B ? route_b_q :
                      index_q == PIR_IDX_CONVERT ? convert_q : 8'h00;
  wire [7:0] rd_mux = hit_index  ? index_q       :
                      hit_data   ? cfg_rd        :
                      hit_master ? master_mode_q :
                      hit_slave  ? slave_mode_q  : 8'h00;
  wire       rd_hit = hit_index || hit_data || hit_master || hit_slave;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= io_req.rd ? rd_mux : 8'h00;
      rvalid_q <= io_req.rd && rd_hit;
    end
  end

  // ----------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------
  logic [3:0] line_s;

  pir_sync u_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in (pci_request_line),
    .sync_out (line_s)
  );

  wire [3:0]  code0 = route_a_q[3:0];
  wire [3:0]  code1 = route_a_q[7:4];
  wire [3:0]  code2 = route_b_q[3:0];
  wire [3:0]  code3 = route_b_q[7:4];
  wire [15:0] map0  = pir_decode(code0);
  wire [15:0] map1  = pir_decode(code1);
  wire [15:0] map2  = pir_decode(code2);
  wire [15:0] map3  = pir_decode(code3);

  // Separate ORs for lines that pass level and lines that become edges
  wire [15:0] lvl_or = ({16{line_s[0] & ~convert_q[0]}} & map0)
                     | ({16{line_s[1] & ~convert_q[1]}} & map1)
                     | ({16{line_s[2] & ~convert_q[2]}} & map2)
                     | ({16{line_s[3] & ~convert_q[3]}} & map3);
  wire [15:0] edg_or = ({16{line_s[0] & convert_q[0]}} & map0)
                     | ({16{line_s[1] & convert_q[1]}} & map1)
                     | ({16{line_s[2] & convert_q[2]}} & map2)
                     | ({16{line_s[3] & convert_q[3]}} & map3);
  wire [15:0] rise   = edg_or & ~comb_prev_q;
  // An edge is a one-cycle high pulse so the controller sees a fresh rise
  // even while the PCI line stays asserted.
  wire [15:0] irq_d  = lvl_or | edge_cnt_q;
  wire [15:0] mode_d = {slave_mode_q, master_mode_q};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      comb_prev_q <= 16'h0000;
      edge_cnt_q  <= 16'h0000;
      irq_q       <= 16'h0000;
      mode_q      <= 16'h0000;
    end else begin
      comb_prev_q <= edg_or;
      edge_cnt_q  <= rise;
      irq_q       <= irq_d;
      mode_q      <= mode_d;
    end
  end

  assign io_rdata           = rdata_q;
  assign io_rvalid          = rvalid_q;
  assign isa_irq_req        = irq_q;
  assign isa_irq_level_mode = mode_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  unlock_idx_a: assert property (@(posedge ref_clk) disable iff (srst)
    (wr_index && io_req.wdata == PIR_UNLOCK_IDX && !open_w) |=> lock_q == PIR_IDX_SEEN)
    else $error("unlock index write not recorded");

  // Host cycles may leave idle gaps, so the key step is judged from the state
  unlock_seq_a: assert property (@(posedge ref_clk) disable iff (srst)
    (wr_data && io_req.wdata == PIR_UNLOCK_KEY && lock_q == PIR_IDX_SEEN) |=> open_w)
    else $error("unlock sequence did not open registers");

  unlock_only_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(open_w) |->
      $past(wr_data && io_req.wdata == PIR_UNLOCK_KEY && lock_q == PIR_IDX_SEEN))
    else $error("registers opened without the unlock pair");

  lock_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    open_w |=> open_w)
    else $error("registers relocked without reset");

  locked_wr_a: assert property (@(posedge ref_clk) disable iff (srst)
    (wr_data && !open_w) |=> $stable(route_a_q) && $stable(route_b_q) && $stable(convert_q))
    else $error("routing changed while locked");

  mode_reset_a: assert property (@(posedge ref_clk)
    $past(srst) |-> master_mode_q == 8'h00 && slave_mode_q == 8'h00)
    else $error("mode ports not zero after reset");

  mode_order_a: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 isa_irq_level_mode == $past({slave_mode_q, master_mode_q}))
    else $error("channel mode bit order wrong");

  mode_rw_a: assert property (@(posedge ref_clk) disable iff (srst)
    (wr_slave && !io_req.rd) ##1 (io_req.rd && hit_slave && !wr_slave)
    |=> io_rdata == $past(io_req.wdata, 2))
    else $error("slave mode port readback wrong");

  master_rd_a: assert property (@(posedge ref_clk) disable iff (srst)
    (io_req.rd && hit_master) |=> io_rvalid && io_rdata == $past(master_mode_q))
    else $error("master mode port readback wrong");

  rd_miss_a: assert property (@(posedge ref_clk) disable iff (srst)
    (io_req.rd && !rd_hit) |=> !io_rvalid && io_rdata == 8'h00)
    else $error("read of an unmapped port answered");

  mode_map_a: assert property (@(posedge ref_clk) disable iff (srst)
    wr_master |=> ##1 isa_irq_level_mode[7:0] == $past(io_req.wdata, 2))
    else $error("master mode write not on channel outputs");

  route_dis_a: assert property (@(posedge ref_clk) disable iff (srst)
    (route_a_q == 8'h00 && route_b_q == 8'h00 && !io_req.wr) |=> ##1 isa_irq_req == 16'h0)
    else $error("request with all lines disabled");

  irq3_level_a: assert property (@(posedge ref_clk) disable iff (srst)
    (code0 == 4'b0010 && !convert_q[0] && line_s[0]) |=> isa_irq_req[3])
    else $error("level request not passed to IRQ3");

  edge_pulse_a: assert property (@(posedge ref_clk) disable iff (srst)
    (edge_cnt_q[11] && !lvl_or[11]) ##1 !lvl_or[11] |-> isa_irq_req[11] ##1 !isa_irq_req[11])
    else $error("edge pulse longer than one cycle");

  convert_bits_a: assert property (@(posedge ref_clk) disable iff (srst)
    wr_convert |=> convert_q[3:0] == $past(io_req.wdata[3:0]))
    else $error("convert bits not stored in order");

  edge_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    (edg_or[11] && $past(edg_or[11])) ##1 !lvl_or[11] |=> !isa_irq_req[11])
    else $error("converted request held as a level");

  convert_upper_a: assert property (@(posedge ref_clk) disable iff (srst)
    convert_q[7:4] == 4'h0)
    else $error("unused convert bits set");

  line_route0_a: assert property (@(posedge ref_clk) disable iff (srst)
    (line_s[0] && !convert_q[0]) |=> (isa_irq_req & $past(map0)) == $past(map0))
    else $error("first line not routed to its channel");

  line_route1_a: assert property (@(posedge ref_clk) disable iff (srst)
    (line_s[1] && !convert_q[1]) |=> (isa_irq_req & $past(map1)) == $past(map1))
    else $error("second line not routed to its channel");

  line_route2_a: assert property (@(posedge ref_clk) disable iff (srst)
    (line_s[2] && !convert_q[2]) |=> (isa_irq_req & $past(map2)) == $past(map2))
    else $error("third line not routed to its channel");

  line_route3_a: assert property (@(posedge ref_clk) disable iff (srst)
    (line_s[3] && !convert_q[3]) |=> (isa_irq_req & $past(map3)) == $past(map3))
    else $error("fourth line not routed to its channel");

  route_wr_a: assert property (@(posedge ref_clk) disable iff (srst)
    wr_route_a |=> route_a_q == $past(io_req.wdata))
    else $error("first routing pair not stored");

  route_wr_b: assert property (@(posedge ref_clk) disable iff (srst)
    wr_route_b |=> route_b_q == $past(io_req.wdata))
    else $error("second routing pair not stored");

  cover_unlock_c: cover property (@(posedge ref_clk) lock_q == PIR_OPEN);
  cover_level_c: cover property (@(posedge ref_clk) |isa_irq_level_mode);
  cover_rw_c: cover property (@(posedge ref_clk) wr_slave ##1 (io_req.rd && hit_slave));
  cover_edge_c: cover property (@(posedge ref_clk) |edge_cnt_q);
  cover_share_c: cover property (@(posedge ref_clk) (map0 == map1) && |map0 && &line_s[1:0]);

endmodule : pir_router

// File: design/pir_sync.sv
`timescale 1ns/1ps
module pir_sync
  import pir_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [3:0] async_in,
  output logic      [3:0] sync_out
);

  logic [3:0] meta_q;
  logic [3:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : pir_sync

// File: tb/pci_pci_request_line_isa_irq_router_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module pci_pci_request_line_isa_irq_router_test;
  import pir_pkg::*;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic        ref_clk;
  logic        srst;
  pir_io_s     io_req;
  logic [7:0]  io_rdata;
  logic        io_rvalid;
  logic [3:0]  pci_request_line;
  logic [15:0] isa_irq_req;
  logic [15:0] isa_irq_level_mode;
  int          mismatches;
  int          cmp_count;
  localparam logic [3:0] RT_CODE [12] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h1, 4'h3,
                                         4'h5, 4'h7, 4'h9, 4'hb, 4'hd, 4'hf};
  localparam int RT_IRQ [12] = '{-1, 3, 4, 7, 9, 10, 5, 6, 11, 12, 14, 15};
  localparam int LINE_IRQ [4] = '{3, 9, 5, 15};

  pir_router DUT (.ref_clk(ref_clk), .srst(srst), .io_req(io_req),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .pci_request_line(pci_request_line),
    .isa_irq_req(isa_irq_req), .isa_irq_level_mode(isa_irq_level_mode));
  pir_far_end far (.ref_clk(ref_clk), .pci_request_line(pci_request_line),
    .isa_irq_req(isa_irq_req));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Host cycles
  // ----------------------------------------------------------------
  function automatic logic [15:0] irq_vec(input int n);
    return (n < 0) ? 16'h0000 : 16'h0001 << n;
  endfunction : irq_vec

  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge ref_clk);
    io_req = '0;
  endtask : io_wr

  // Answer stands one cycle after the read edge, so look at the next falling edge
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] d, input logic v);
    @(negedge ref_clk);
    io_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    io_req = '0;
    `CHK(io_rvalid, v)
    `CHK(io_rdata, d)
  endtask : rd_chk

  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
    io_wr(PIR_PORT_INDEX, idx);
    io_wr(PIR_PORT_DATA, d);
  endtask : cfg_wr

  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] d);
    io_wr(PIR_PORT_INDEX, idx);
    rd_chk(PIR_PORT_DATA, d, 1'b1);
  endtask : cfg_rd

  task automatic line_chk(input logic [3:0] v, input logic [15:0] e);
    @(negedge ref_clk);
    far.drive(v);
    repeat (5) @(negedge ref_clk);
    `CHK(isa_irq_req, e)
  endtask : line_chk
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(PIR_PORT_MASTER, 8'h00, 1'b1);
    rd_chk(PIR_PORT_SLAVE, 8'h00, 1'b1);
    `CHK(isa_irq_level_mode, 16'h0000)
    rd_chk(16'h0080, 8'h00, 1'b0);
    io_wr(PIR_PORT_INDEX, PIR_UNLOCK_IDX);
    io_wr(PIR_PORT_DATA, 8'h55);
    cfg_wr(PIR_IDX_ROUTE_A, 8'h12);
    cfg_rd(PIR_IDX_ROUTE_A, 8'h00);
    line_chk(4'h1, 16'h0000);
    line_chk(4'h0, 16'h0000);
  endtask : t_reset

  task automatic t_ports();
    io_wr(PIR_PORT_MASTER, 8'ha8);
    io_wr(PIR_PORT_SLAVE, 8'hde);
    rd_chk(PIR_PORT_MASTER, 8'ha8, 1'b1);
    rd_chk(PIR_PORT_SLAVE, 8'hde, 1'b1);
    `CHK(isa_irq_level_mode, 16'hdea8)
    // Write and read of one port in back-to-back cycles
    @(negedge ref_clk);
    io_req = '{rd: 1'b0, wr: 1'b1, addr: PIR_PORT_SLAVE, wdata: 8'h5a};
    @(negedge ref_clk);
    io_req = '{rd: 1'b1, wr: 1'b0, addr: PIR_PORT_SLAVE, wdata: 8'h00};
    @(negedge ref_clk);
    io_req = '0;
    `CHK(io_rdata, 8'h5a)
    io_wr(PIR_PORT_MASTER, 8'h00);
    io_wr(PIR_PORT_SLAVE, 8'h00);
  endtask : t_ports

  task automatic t_route();
    // Every channel a level line can reach is set to level mode
    io_wr(PIR_PORT_MASTER, 8'hf8);
    io_wr(PIR_PORT_SLAVE, 8'hde);
    io_wr(PIR_PORT_INDEX, PIR_UNLOCK_IDX);
    io_wr(PIR_PORT_DATA, PIR_UNLOCK_KEY);
    `CHK(isa_irq_level_mode, 16'hdef8)
    cfg_wr(PIR_IDX_CONVERT, 8'h00);
    // Reserved codes are never written
    for (int i = 0; i < 12; i++) begin
      cfg_wr(PIR_IDX_ROUTE_A, {4'h0, RT_CODE[i]});
      cfg_rd(PIR_IDX_ROUTE_A, {4'h0, RT_CODE[i]});
      line_chk(4'h1, irq_vec(RT_IRQ[i]));
      line_chk(4'h0, 16'h0000);
    end
  endtask : t_route

  task automatic t_fields();
    cfg_wr(PIR_IDX_ROUTE_A, 8'h12);
    cfg_wr(PIR_IDX_ROUTE_B, 8'hf5);
    cfg_rd(PIR_IDX_ROUTE_B, 8'hf5);
    for (int i = 0; i < 4; i++) begin
      line_chk(4'h1 << i, irq_vec(LINE_IRQ[i]));
    end
    line_chk(4'h0, 16'h0000);
  endtask : t_fields

  task automatic t_convert();
    // Shared channel left edge triggered to match the converted lines
    io_wr(PIR_PORT_SLAVE, 8'h00);
    cfg_wr(PIR_IDX_ROUTE_A, 8'h99);
    cfg_wr(PIR_IDX_CONVERT, 8'hf3);
    cfg_rd(PIR_IDX_CONVERT, 8'h03);
    far.clear_counts();
    line_chk(4'h1, 16'h0000);
    line_chk(4'h3, 16'h0000);
    `CHK(far.hi_cnt[11], 1)
    line_chk(4'h0, 16'h0000);
    line_chk(4'h2, 16'h0000);
    `CHK(far.hi_cnt[11], 2)
    line_chk(4'h0, 16'h0000);
    // Line one converted, line zero passed as level onto a level channel
    io_wr(PIR_PORT_MASTER, 8'h08);
    cfg_wr(PIR_IDX_ROUTE_A, 8'h12);
    cfg_wr(PIR_IDX_CONVERT, 8'h02);
    far.clear_counts();
    line_chk(4'h1, irq_vec(3));
    line_chk(4'h3, irq_vec(3));
    `CHK(far.hi_cnt[9], 1)
    // Two level lines on one channel hold it while either is up
    io_wr(PIR_PORT_SLAVE, 8'h08);
    cfg_wr(PIR_IDX_ROUTE_A, 8'h99);
    cfg_wr(PIR_IDX_CONVERT, 8'h00);
    line_chk(4'h3, irq_vec(11));
    line_chk(4'h2, irq_vec(11));
    line_chk(4'h0, 16'h0000);
  endtask : t_convert

  task automatic summarize();
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    io_req = '0;
    srst = 1'b1;
    mismatches = 0;
    cmp_count = 0;
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    t_reset();
    t_ports();
    t_route();
    t_fields();
    t_convert();
    summarize();
  end

  // Whole run needs a few hundred cycles; this is far past it
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end
endmodule : pci_pci_request_line_isa_irq_router_test

// File: tb/pir_far_end.sv
`timescale 1ns/1ps
module pir_far_end
  import pir_pkg::*;
(
  // Clock
  input  wire logic        ref_clk,
  // PCI sources out, interrupt controller requests in
  output logic      [3:0]  pci_request_line,
  input  wire logic [15:0] isa_irq_req
);
  int hi_cnt [16];

  // Released lines are pulled to the inactive level
  initial pci_request_line = 4'h0;

  task automatic drive(input logic [3:0] v);
    pci_request_line = v;
  endtask : drive

  task automatic clear_counts();
    foreach (hi_cnt[i]) hi_cnt[i] = 0;
  endtask : clear_counts

  // High cycles per channel; a converted request must count exactly one
  always @(posedge ref_clk) begin
    foreach (hi_cnt[i]) if (isa_irq_req[i] === 1'b1) hi_cnt[i]++;
  end
endmodule : pir_far_end
